/* rtl/sfm_pkg.sv */
// sfm_pkg: constants and carriers for the seam fade and swing sequencer
// assumes one 25 MHz clock; power in watts, ratios in tenths of a percent
package sfm_pkg;
    localparam int          CLK_HZ         = 25_000_000;
    localparam int          TABLE_POINTS   = 20;
    localparam logic [13:0] SHOT_MAX       = 14'h270F;  // 9999, also endless
    localparam logic [13:0] FIRST_END      = 14'h0001;
    localparam logic [10:0] LEVEL_MAX      = 11'h5DC;   // 150.0 percent
    localparam logic [10:0] LEVEL_FLOOR    = 11'h001;   // 0.1 percent
    localparam logic [10:0] RATIO_FULL     = 11'h3E8;   // 100.0 percent
    localparam logic [12:0] MIN_POWER_W    = 13'h03E8;  // 1.000 kW
    localparam logic [12:0] MAX_POWER_W    = 13'h157C;  // 5.500 kW
    localparam logic [6:0]  DUTY_MIN       = 7'h0A;
    localparam logic [6:0]  DUTY_MAX       = 7'h5A;
    localparam logic [6:0]  DEPTH_MAX      = 7'h64;
    localparam logic [12:0] FREQ_MAX       = 13'h1388;  // 5000 Hz
    localparam int          PHASE_STEPS    = 100;
    localparam logic [7:0]  PHASE_LAST     = 8'h63;
    localparam logic [12:0] POWER_RESET    = 13'h0000;

    typedef enum logic [1:0] {SFM_SQUARE, SFM_TRIANGLE, SFM_HARMONIC} sfm_shape_e;
    typedef enum {SFM_IDLE, SFM_RUN} sfm_state_e;

    typedef struct packed {
        logic [13:0] end_index;
        logic [10:0] level;
    } sfm_point_s;

    typedef struct packed {
        logic       swing_enable;
        sfm_shape_e shape;
        logic [6:0] duty;
        logic [6:0] depth;
        logic [12:0] freq_hz;
    } sfm_swing_s;
endpackage

/* rtl/sfm_table.sv */
// sfm_table: twenty-entry breakpoint store with entry checks
// assumes writes come one entry at a time from the operator side
module sfm_table
    import sfm_pkg::*;
#(
    parameter int POINTS = TABLE_POINTS
)(
    input  wire logic                      clock,
    input  wire logic                      sys_rst,
    input  wire logic                      clk_en,
    input  wire logic                      wr_en,
    input  wire logic [4:0]                wr_idx,
    input  wire sfm_pkg::sfm_point_s       wr_point,
    input  wire logic [12:0]               peak_w,
    output logic                           wr_reject,
    output sfm_pkg::sfm_point_s [19:0]     points
);
    import sfm_pkg::*;

    sfm_point_s mem [POINTS];
    wire  [13:0] prev_end  = (wr_idx == 5'h00) ? 14'h0000 : mem[wr_idx - 5'h01].end_index;
    wire  [23:0] product   = peak_w * wr_point.level;
    wire         first_bad = (wr_idx == 5'h00) && (wr_point.end_index != FIRST_END);
    wire         order_bad = (wr_point.end_index != 14'h0000)
                           && ((wr_point.end_index > SHOT_MAX)
                           || (wr_point.end_index <= prev_end));
    wire         level_bad = (wr_point.level > LEVEL_MAX)
                           || ((wr_point.level >= LEVEL_FLOOR)
                           && (product < 24'(MIN_POWER_W) * 24'(RATIO_FULL)));
    wire         bad       = first_bad || order_bad || level_bad
                           || (wr_idx >= 5'(POINTS));

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            wr_reject <= 1'b0;
            for (int i = 0; i < POINTS; i++)
                mem[i] <= '0;
        end
        else if (clk_en)
        begin
            wr_reject <= wr_en && bad;
            if (wr_en && !bad)
                mem[wr_idx] <= wr_point;
        end
    end

    generate
        for (genvar g = 0; g < 20; g++)
        begin : g_out
            if (g < POINTS)
                assign points[g] = mem[g];
            else
                assign points[g] = '0;
        end
    endgenerate

    a_first_fixed: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en && wr_en && wr_idx == 5'h00 && wr_point.end_index != FIRST_END
        |=> wr_reject) else $error("first entry accepted with wrong end");
    a_level_range: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en && wr_en && wr_point.level > LEVEL_MAX |=> wr_reject)
        else $error("level above limit accepted");
endmodule // sfm_table

/* rtl/sfm_swing.sv */
// sfm_swing: periodic swing generator, returns signed offset in watts
// assumes settings are validated by the caller and held during a burst
module sfm_swing
    import sfm_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic                 clk_en,
    input  wire logic                 restart,
    input  wire sfm_pkg::sfm_swing_s  cfg,
    input  wire logic [12:0]          peak_w,
    output logic signed [13:0]        offset_w
);
    import sfm_pkg::*;

    // period split into 100 phase steps of CLK_HZ/(freq*100) cycles
    logic [23:0] div_cnt;
    logic [7:0]  phase;
    wire  [23:0] step_len = 24'(CLK_HZ / PHASE_STEPS) / {11'h000, cfg.freq_hz};
    wire         step     = (div_cnt + 24'h000001 >= step_len);
    wire  [19:0] amp      = (20'(peak_w) * 20'(cfg.depth)) / 20'd200;
    wire         high     = {1'b0, phase} < {1'b0, cfg.duty};
    wire  [7:0]  tri_pos  = (phase < 8'd50) ? phase : 8'(PHASE_LAST - phase);
    // coarse harmonic_shape: parabola per half cycle, good to a few percent
    wire  [7:0]  half     = (phase < 8'd50) ? phase : 8'(phase - 8'd50);
    wire  [15:0] para     = 16'(half) * 16'(8'd50 - half) * 16'd4 / 16'd25;
    wire  signed [20:0] tri_val = 21'(signed'({1'b0, amp}) * (4 * $signed({1'b0, tri_pos}) - 98) / 98);
    wire  signed [20:0] sin_val = (phase < 8'd50) ?  21'(amp * para / 100)
                                                 : -21'(amp * para / 100);
    wire  signed [20:0] sq_val  = high ? 21'(amp) : -21'(amp);
    logic signed [20:0] sel;

    always_comb
    begin
        case (cfg.shape)
            SFM_SQUARE:   sel = sq_val;
            SFM_TRIANGLE: sel = tri_val;
            SFM_HARMONIC: sel = sin_val;
            default:      sel = 21'sd0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst || (clk_en && restart))
        begin
            div_cnt  <= '0;
            phase    <= '0;
            offset_w <= '0;
        end
        else if (clk_en)
        begin
            div_cnt  <= step ? '0 : div_cnt + 24'h000001;
            if (step)
                phase <= (phase == PHASE_LAST) ? 8'h00 : phase + 8'h01;
            offset_w <= cfg.swing_enable ? 14'(sel) : 14'sd0;
        end
    end

    a_off_flat: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en && !restart && !cfg.swing_enable |=> offset_w == 14'sd0)
        else $error("swing present while disabled");
endmodule // sfm_swing

/* rtl/sfm_sequencer.sv */
// sfm_sequencer: per-shot power setpoint from fade table and periodic swing
// assumes operator settings are static during a burst and shot_strobe marks each shot

// What this block does
// - table takes effect only if pulse rate and shot total are both nonzero
// - first breakpoint end index must be one
// - breakpoint level limited to 0 through 150.0 percent of peak
// - nonzero level must give at least 1.000 kW with the peak
// - twenty breakpoints, end indices 1 through 9999
// - end indices strictly rising; zero marks an unused entry
// - breakpoints past the shot total are ignored; burst stops at total
// - beyond the last breakpoint its level repeats until the total
// - setpoint never drops below 1.000 kW while firing, except 0 W in the first firing cycle
// - fade enable routes table levels; otherwise table is ignored
// - total 9999 means endless until stop; table disabled then
// - swing high fraction 10 to 90 percent
// - swing depth 0 to 100 percent of peak, centred on peak or, while fading, on the table level of peak
// - reject depth whose swing leaves 1.000 kW to maximum window
// - swing rate 1 to 5000 Hz sets its period
// - swing enable applies swing; off means none
// - swing shape is square, triangle or harmonic
// - with swing, shot may run slightly past set time
module sfm_sequencer
    import sfm_pkg::*;
#(
    parameter int POINTS = TABLE_POINTS
)(
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    input  wire logic                  clk_en,
    input  wire logic                  burst_start,
    input  wire logic                  stop_req,
    input  wire logic                  shot_strobe,
    input  wire logic                  fade_enable,
    input  wire logic [9:0]            pulse_rate,
    input  wire logic [13:0]           shot_total,
    input  wire logic [12:0]           peak_w,
    input  wire logic                  tbl_wr_en,
    input  wire logic [4:0]            tbl_wr_idx,
    input  wire sfm_pkg::sfm_point_s   tbl_wr_point,
    input  wire logic                  swing_wr_en,
    input  wire sfm_pkg::sfm_swing_s   swing_wr_cfg,
    output logic                       tbl_reject,
    output logic                       swing_reject,
    output logic                       firing,
    output logic [13:0]                shot_count,
    output logic [12:0]                power_w
);
    import sfm_pkg::*;

    sfm_state_e         state;
    sfm_swing_s         swing_cfg;
    sfm_point_s [19:0]  points;
    logic               tbl_rej_int;
    logic signed [13:0] offset_w;

    // the table store rejects bad entries itself
    sfm_table #(.POINTS(POINTS)) u_table (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .wr_en     (tbl_wr_en),
        .wr_idx    (tbl_wr_idx),
        .wr_point  (tbl_wr_point),
        .peak_w    (peak_w),
        .wr_reject (tbl_rej_int),
        .points    (points)
    );

    sfm_swing u_swing (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .restart  (burst_start),
        .cfg      (swing_cfg),
        .peak_w   (peak_w),
        .offset_w (offset_w)
    );

    // swing limits: half the swing either side of peak must stay in window
    wire [19:0] half_w     = (20'(swing_wr_cfg.depth) * 20'(peak_w)) / 20'd200;
    wire        swing_bad  = (swing_wr_cfg.duty < DUTY_MIN)
                          || (swing_wr_cfg.duty > DUTY_MAX)
                          || (swing_wr_cfg.depth > DEPTH_MAX)
                          || (swing_wr_cfg.freq_hz == 13'h0000)
                          || (swing_wr_cfg.freq_hz > FREQ_MAX)
                          || (swing_wr_cfg.shape > SFM_HARMONIC)
                          || (20'(peak_w) + half_w > 20'(MAX_POWER_W))
                          || (20'(peak_w) < half_w + 20'(MIN_POWER_W));

    wire        settings_ok = (pulse_rate != 10'h000) && (shot_total != 14'h0000);
    wire        endless     = (shot_total == SHOT_MAX);
    wire        fade_active = fade_enable && settings_ok && !endless;

    // first breakpoint whose end index is not below the next shot number
    function automatic logic [10:0] pick_level(input sfm_point_s [19:0] tbl,
                                               input logic [13:0] shot,
                                               input logic [13:0] total);
        logic        found;
        logic [10:0] last;
        logic [10:0] lvl;
        found = 1'b0;
        last  = RATIO_FULL;
        lvl   = RATIO_FULL;
        for (int i = 0; i < 20; i++)
        begin
            if (tbl[i].end_index != 14'h0000 && tbl[i].end_index <= total)
            begin
                last = tbl[i].level;
                if (!found && tbl[i].end_index >= shot)
                begin
                    found = 1'b1;
                    lvl   = tbl[i].level;
                end
            end
        end
        return found ? lvl : last;
    endfunction

    wire [13:0] shot_num   = shot_count + 14'h0001;
    wire [10:0] ratio      = fade_active ? pick_level(points, shot_num, shot_total)
                                         : RATIO_FULL;
    wire [23:0] base_prod  = 24'(peak_w) * 24'(ratio) / 24'(RATIO_FULL);
    // 150 percent of a high peak overflows 13 bits; saturate before adding the swing
    wire [12:0] base_w     = (base_prod > 24'(MAX_POWER_W)) ? MAX_POWER_W
                                                            : base_prod[12:0];
    wire signed [15:0] sum = $signed({3'b000, base_w}) + 16'(offset_w);
    wire [12:0] floored    = (sum < $signed({3'b000, MIN_POWER_W})) ? MIN_POWER_W
                           : (sum > $signed({3'b000, MAX_POWER_W})) ? MAX_POWER_W
                           : sum[12:0];
    wire        last_shot  = !endless && (shot_num >= shot_total);
    wire        run_ok     = settings_ok && !stop_req;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state        <= SFM_IDLE;
            swing_cfg    <= '0;
            swing_reject <= 1'b0;
            tbl_reject   <= 1'b0;
            firing       <= 1'b0;
            shot_count   <= '0;
            power_w      <= POWER_RESET;
        end
        else if (clk_en)
        begin
            tbl_reject   <= tbl_rej_int;
            swing_reject <= swing_wr_en && swing_bad;
            if (swing_wr_en && !swing_bad)
                swing_cfg <= swing_wr_cfg;
            case (state)
                SFM_IDLE:
                begin
                    power_w <= POWER_RESET;
                    firing  <= 1'b0;
                    if (burst_start && run_ok)
                    begin
                        state      <= SFM_RUN;
                        shot_count <= '0;
                        firing     <= 1'b1;
                    end
                end
                SFM_RUN:
                begin
                    // swing keeps moving the level mid-shot; shot may run a touch long
                    power_w <= floored;
                    if (stop_req)
                    begin
                        state   <= SFM_IDLE;
                        firing  <= 1'b0;
                        power_w <= POWER_RESET;
                    end
                    else if (shot_strobe)
                    begin
                        shot_count <= endless ? shot_count : shot_num;
                        if (last_shot)
                        begin
                            state  <= SFM_IDLE;
                            firing <= 1'b0;
                        end
                    end
                end
                default: state <= SFM_IDLE;
            endcase
        end
    end

    a_floor_held: assert property (@(posedge clock) disable iff (sys_rst)
        firing && $past(firing) && clk_en |-> power_w >= MIN_POWER_W)
        else $error("power below floor while firing");
    a_start_gate: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en && state == SFM_IDLE && burst_start && !settings_ok |=> !firing)
        else $error("burst started with zero rate or total");
    a_burst_clear: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en && state == SFM_IDLE && burst_start && run_ok |=> shot_count == 14'h0000)
        else $error("shot counter not cleared at burst start");
    a_total_end: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en && state == SFM_RUN && shot_strobe && !stop_req && last_shot
        |=> !firing ##1 power_w == POWER_RESET)
        else $error("burst ran past total");
    a_endless_run: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en && state == SFM_RUN && endless && !stop_req && shot_strobe |=> firing)
        else $error("endless burst ended without stop");
    a_stop_ends: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en && state == SFM_RUN && stop_req |=> !firing && power_w == POWER_RESET)
        else $error("stop did not end burst");
    a_swing_reject: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en && swing_wr_en && (swing_wr_cfg.duty < DUTY_MIN
        || swing_wr_cfg.duty > DUTY_MAX) |=> swing_reject)
        else $error("duty out of range accepted");
    a_depth_window: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en && swing_wr_en && 20'(peak_w) + half_w > 20'(MAX_POWER_W)
        |=> swing_reject && $stable(swing_cfg))
        else $error("depth beyond maximum accepted");
endmodule // sfm_sequencer

/* dv/sfm_driver_model.sv */
// sfm_driver_model: stand-in laser power driver, fires shots and logs setpoints
// assumes one clock shared with the sequencer; shots spaced ten cycles apart
module sfm_driver_model
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        run,
    input  wire logic        firing,
    input  wire logic [12:0] power_w,
    output logic             shot_strobe,
    output logic [12:0]      min_w,
    output logic [12:0]      max_w,
    output logic [15:0]      shots
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] gap;
    wire        fire_now = firing && gap == 4'h9;
    // shoots only while the sequencer reports firing, as the real driver would
    always @(posedge clock)
    begin
        if (sys_rst || !run)
        begin
            {shot_strobe, gap, shots} <= '0;
            min_w <= 13'h1FFF;
            max_w <= 13'h0000;
        end
        else
        begin
            shot_strobe <= fire_now;
            gap <= (gap == 4'h9) ? 4'h0 : gap + 4'h1;
            shots <= shots + 16'(fire_now);
            // zero means setpoint not yet valid, so it is kept out of the span
            if (firing && power_w != 13'h0000 && power_w < min_w)
                min_w <= power_w;
            if (firing && power_w > max_w)
                max_w <= power_w;
        end
    end
endmodule // sfm_driver_model

/* dv/sfm_sequencer_tb.sv */
// sfm_sequencer_tb: self-checking bench for the fade and swing sequencer
// assumes sfm_pkg and the driver model are compiled first; clk_en held high
module sfm_sequencer_tb;
    import sfm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, sys_rst, clk_en, burst_start, stop_req, shot_strobe;
    logic        fade_enable, tbl_wr_en, swing_wr_en, run;
    logic        tbl_reject, swing_reject, firing;
    logic [9:0]  pulse_rate;
    logic [13:0] shot_total, shot_count;
    logic [12:0] peak_w, power_w, min_w, max_w;
    logic [4:0]  tbl_wr_idx;
    logic [15:0] shots;
    sfm_point_s  tbl_wr_point;
    sfm_swing_s  swing_wr_cfg;
    int          failures = 0;
    int          tests_run = 0;
    int          cycles = 0;

    sfm_sequencer sfm_sequencer_inst (.clock, .sys_rst, .clk_en, .burst_start, .stop_req,
        .shot_strobe, .fade_enable, .pulse_rate, .shot_total, .peak_w, .tbl_wr_en,
        .tbl_wr_idx, .tbl_wr_point, .swing_wr_en, .swing_wr_cfg, .tbl_reject,
        .swing_reject, .firing, .shot_count, .power_w);
    sfm_driver_model sfm_driver_model_inst (.clock, .sys_rst, .run, .firing, .power_w,
        .shot_strobe, .min_w, .max_w, .shots);

    always #20 clock = ~clock;

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            failures++;
            wrap_up();
        end
    end

    task automatic cyc(int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // expected setpoint: ratio of peak, then held inside the output window
    function automatic logic [15:0] pw(logic [10:0] r);
        logic [31:0] v;
        v = 32'(peak_w) * 32'(r) / 32'h3E8;
        if (v < 32'(MIN_POWER_W)) v = 32'(MIN_POWER_W);
        if (v > 32'(MAX_POWER_W)) v = 32'(MAX_POWER_W);
        return v[15:0];
    endfunction

    task automatic wr(logic sw, logic rej);
        logic seen;
        seen = 1'b0;
        @(posedge clock);
        if (sw) swing_wr_en <= 1'b1;
        else tbl_wr_en <= 1'b1;
        @(posedge clock);
        {swing_wr_en, tbl_wr_en} <= 2'b00;
        // swing reject stands only in the cycle right after the write edge
        #1 seen = sw ? swing_reject : tbl_reject;
        repeat (3)
        begin
            @(posedge clock);
            #1 seen = seen | (sw ? swing_reject : tbl_reject);
        end
        chk(sw ? "swing_reject" : "tbl_reject", 16'(rej), 16'(seen));
    endtask

    task automatic wr_pt(logic [4:0] i, logic [13:0] e, logic [10:0] l, logic rej);
        tbl_wr_idx <= i;
        tbl_wr_point <= {e, l};
        wr(1'b0, rej);
    endtask

    task automatic wr_sw(logic en, sfm_shape_e s, logic [6:0] d, logic [6:0] m,
                         logic [12:0] f, logic rej);
        swing_wr_cfg <= {en, s, d, m, f};
        wr(1'b1, rej);
    endtask

    task automatic burst(logic [13:0] tot, logic fade);
        @(posedge clock);
        {shot_total, fade_enable, burst_start} <= {tot, fade, 1'b1};
        @(posedge clock);
        {burst_start, run} <= 2'b01;
        cyc(2);
    endtask

    task automatic at(logic [13:0] k, logic [10:0] r);
        for (int n = 0; n < 400 && shot_count !== k; n++)
        begin
            @(posedge clock);
            #1;
        end
        cyc(2);
        #1 chk("power_w", pw(r), 16'(power_w));
    endtask

    task automatic drain(logic [13:0] k);
        for (int n = 0; n < 400 && firing !== 1'b0; n++)
        begin
            @(posedge clock);
            #1;
        end
        cyc(2);
        #1 chk("shot_count", 16'(k), 16'(shot_count));
        chk("power_w", 16'h0000, 16'(power_w));
        chk("shots", 16'(k), shots);
        run <= 1'b0;
    endtask

    task automatic halt();
        @(posedge clock);
        stop_req <= 1'b1;
        @(posedge clock);
        {stop_req, run} <= 2'b00;
        cyc(2);
        #1 chk("firing", 16'h0000, 16'(firing));
    endtask

    task automatic t_table();
        wr_pt(5'h00, 14'h0002, 11'h3E8, 1'b1);
        wr_pt(5'h00, 14'h0001, 11'h5DD, 1'b1);
        wr_pt(5'h00, 14'h0001, 11'h0C8, 1'b1);
        wr_pt(5'h00, 14'h0001, 11'h1F4, 1'b0);
        wr_pt(5'h01, 14'h0005, 11'h3E8, 1'b0);
        wr_pt(5'h02, 14'h0005, 11'h0FA, 1'b1);
        wr_pt(5'h02, 14'h2710, 11'h0FA, 1'b1);
        wr_pt(5'h02, 14'h000A, 11'h0FA, 1'b0);
        wr_pt(5'h03, 14'h000C, 11'h000, 1'b0);
        wr_pt(5'h04, 14'h000E, 11'h55F, 1'b0);
        wr_pt(5'h14, 14'h0010, 11'h3E8, 1'b1);
        $display("test table_writes done");
    endtask

    task automatic t_fade();
        burst(14'h0014, 1'b1);
        at(14'h0000, 11'h1F4);
        at(14'h0003, 11'h3E8);
        at(14'h0007, 11'h0FA);
        at(14'h000B, 11'h000);
        at(14'h000D, 11'h55F);
        at(14'h0011, 11'h55F);
        drain(14'h0014);
        burst(14'h0008, 1'b1);
        drain(14'h0008);
        burst(14'h0014, 1'b0);
        at(14'h0007, 11'h3E8);
        halt();
        $display("test fade_run done");
    endtask

    task automatic t_idle();
        pulse_rate <= 10'h000;
        burst(14'h0014, 1'b1);
        #1 chk("firing", 16'h0000, 16'(firing));
        pulse_rate <= 10'h00A;
        burst(14'h0000, 1'b1);
        #1 chk("firing", 16'h0000, 16'(firing));
        run <= 1'b0;
        burst(SHOT_MAX, 1'b1);
        at(14'h0000, 11'h3E8);
        cyc(200);
        #1 chk("firing", 16'h0001, 16'(firing));
        at(14'h0000, 11'h3E8);
        halt();
        $display("test idle_and_endless done");
    endtask

    task automatic t_swing();
        peak_w <= 13'h1130;
        wr_sw(1'b1, SFM_SQUARE, 7'h09, 7'h32, 13'h1388, 1'b1);
        wr_sw(1'b1, SFM_SQUARE, 7'h5B, 7'h32, 13'h1388, 1'b1);
        wr_sw(1'b1, SFM_SQUARE, 7'h0A, 7'h32, 13'h1388, 1'b0);
        wr_sw(1'b1, SFM_SQUARE, 7'h5A, 7'h00, 13'h0001, 1'b0);
        wr_sw(1'b1, SFM_SQUARE, 7'h32, 7'h65, 13'h1388, 1'b1);
        wr_sw(1'b1, SFM_SQUARE, 7'h32, 7'h34, 13'h1388, 1'b1);
        wr_sw(1'b1, SFM_SQUARE, 7'h32, 7'h32, 13'h0000, 1'b1);
        wr_sw(1'b1, SFM_SQUARE, 7'h32, 7'h32, 13'h1389, 1'b1);
        peak_w <= 13'h04B0;
        wr_sw(1'b1, SFM_SQUARE, 7'h32, 7'h28, 13'h1388, 1'b1);
        peak_w <= 13'h1130;
        // depth 50 at 4400 W swings exactly 3300 to 5500 W
        for (int s = 0; s < 3; s++)
        begin
            wr_sw(1'b1, sfm_shape_e'(s), 7'h32, 7'h32, 13'h1388, 1'b0);
            burst(SHOT_MAX, 1'b0);
            cyc(5200);
            #1 chk("swing_span", 16'h0001, 16'(max_w <= 13'h157C && min_w >= 13'h0CE4
                   && max_w > min_w + 13'h03E8));
            if (s == 0) chk("max_w", 16'h157C, 16'(max_w));
            if (s == 0) chk("min_w", 16'h0CE4, 16'(min_w));
            halt();
        end
        wr_sw(1'b0, SFM_SQUARE, 7'h32, 7'h32, 13'h1388, 1'b0);
        burst(SHOT_MAX, 1'b0);
        cyc(5200);
        #1 chk("max_w", 16'h1130, 16'(max_w));
        chk("min_w", 16'h1130, 16'(min_w));
        halt();
        $display("test swing done");
    endtask

    initial
    begin
        {clock, burst_start, stop_req, fade_enable, tbl_wr_en, swing_wr_en, run} = '0;
        {clk_en, sys_rst} = 2'b11;
        pulse_rate = 10'h00A;
        shot_total = 14'h0014;
        peak_w = 13'h0FA0;
        {tbl_wr_idx, tbl_wr_point, swing_wr_cfg} = '0;
        cyc(6);
        sys_rst <= 1'b0;
        cyc(1);
        #1 chk("shot_count", 16'h0000, 16'(shot_count));
        chk("power_w", 16'h0000, 16'(power_w));
        $display("test reset done");
        t_table();
        t_fade();
        t_idle();
        t_swing();
        wrap_up();
    end
endmodule // sfm_sequencer_tb
